// ==== verilog/link_bringup_pkg.sv ====
/*
 * Constants, register map and carrier types for the receive-link bring-up sequencer.
 * Assumes one 100 MHz system clock and a byte-wide register port fed by the serial
 * port decoder.
 */
package link_bringup_pkg;

	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 8;
	localparam int LANE_COUNT = 4;
	localparam int LANE_W     = 10;
	localparam int SEL_W      = 3;

	// register offsets
	localparam logic [ADDR_W-1:0] LMFC_SYNC_CONTROL_ADDR   = 12'h03a;
	localparam logic [ADDR_W-1:0] LMFC_SYNC_STATUS_ADDR    = 12'h03b;
	localparam logic [ADDR_W-1:0] CDR_RESET_CONTROL_ADDR   = 12'h206;
	localparam logic [ADDR_W-1:0] PHY_CLOCKING_SETUP_ADDR  = 12'h230;
	localparam logic [ADDR_W-1:0] EQUALIZER_SETUP_ADDR     = 12'h268;
	localparam logic [ADDR_W-1:0] SERDES_PLL_ENABLE_ADDR   = 12'h280;
	localparam logic [ADDR_W-1:0] SERDES_PLL_STATUS_ADDR   = 12'h281;
	localparam logic [ADDR_W-1:0] SERDES_PLL_DIVIDER_ADDR  = 12'h289;
	localparam logic [ADDR_W-1:0] PHY_AUTOTUNE_ADDR        = 12'h2a7;
	localparam logic [ADDR_W-1:0] LINK_CONTROL_ADDR        = 12'h300;
	localparam logic [ADDR_W-1:0] LINK_SUBCLASS_ADDR       = 12'h301;
	localparam logic [ADDR_W-1:0] FRAME_CLOCK_DELAY_ADDR   = 12'h304;
	localparam logic [ADDR_W-1:0] FRAME_CLOCK_VAR_ADDR     = 12'h306;
	localparam logic [ADDR_W-1:0] LANE_CROSSBAR_LOW_ADDR   = 12'h308;
	localparam logic [ADDR_W-1:0] LANE_CROSSBAR_HIGH_ADDR  = 12'h309;
	localparam logic [ADDR_W-1:0] SERDES_PORT_CONFIG_ADDR  = 12'h314;
	localparam logic [ADDR_W-1:0] LANE_POLARITY_INV_ADDR   = 12'h334;

	// reset values and command bytes
	localparam logic [DATA_W-1:0] ZERO_BYTE            = 8'h00;
	localparam logic [DATA_W-1:0] PHY_CLOCKING_RESET   = 8'h09;
	localparam logic [DATA_W-1:0] EQUALIZER_RESET      = 8'h22;
	localparam logic [DATA_W-1:0] SYNC_CMD_ONE_SHOT    = 8'h01;
	localparam logic [DATA_W-1:0] SYNC_CMD_ENABLE      = 8'h81;
	localparam logic [DATA_W-1:0] SYNC_CMD_ARM         = 8'hc1;
	localparam logic [DATA_W-1:0] PLL_ENABLE_CMD       = 8'h01;

	// field positions
	localparam int SYNC_ENABLE_BIT   = 7;
	localparam int SYNC_ARM_BIT      = 6;
	localparam int SYNC_MODE_LSB     = 0;
	localparam logic [1:0] SYNC_MODE_ONE_SHOT = 2'h1;
	localparam int SYNC_LOCKED_BIT   = 3;
	localparam int CDR_RELEASE_BIT   = 0;
	localparam int PLL_ENABLE_BIT    = 0;
	localparam int PLL_LOCK_BIT      = 0;
	localparam int LINK_ENABLE_BIT   = 0;
	localparam int CHECKSUM_MODE_BIT = 6;
	localparam int EQ_MODE_LSB       = 6;
	localparam int HALFRATE_BIT      = 5;
	localparam int PLL_CFG_LSB       = 2;
	localparam int OVERSAMPLE_BIT    = 1;
	localparam int SWING_BIT         = 0;
	localparam int DIV_CFG_BIT       = 2;
	localparam logic [DATA_W-1:0] SUBCLASS_ONE = 8'h01;

	typedef enum logic [1:0] {
		SYNC_IDLE    = 2'b00,
		SYNC_ENABLED = 2'b01,
		SYNC_ARMED   = 2'b10,
		SYNC_LOCKED  = 2'b11
	} sync_state_e;

	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    wdata;
	} reg_req_s;

	typedef struct packed {
		logic                 halfrate;
		logic [2:0]           pll_cfg;
		logic                 cdr_oversample_select;
		logic                 sync_swing;
		logic [1:0]           serdes_pll_divider_value;
		logic                 divider_cfg;
		logic [1:0]           equalizer_mode_select;
		logic [5:0]           equalizer_trim;
	} phy_cfg_s;

	typedef struct packed {
		logic [DATA_W-1:0]    frame_clock_delay_value;
		logic [DATA_W-1:0]    frame_clock_variability_value;
	} latency_cfg_s;

	typedef logic [LANE_COUNT-1:0][LANE_W-1:0] lane_bus_t;
	typedef logic [2*DATA_W-1:0]               crossbar_t;

endpackage : link_bringup_pkg

// ==== verilog/lane_router.sv ====
/*
 * Lane crossbar and polarity inversion for the receive lanes.
 * Assumes lane symbols arrive synchronous to clk_sys_i; output is registered.
 */
`timescale 1ns/1ns
module lane_router
	import link_bringup_pkg::*;
(
	input  wire logic      clk_sys_i,
	input  wire logic      rst_i,
	input  wire lane_bus_t phys_lanes_i,
	input  wire crossbar_t lane_crossbar_map_i,
	input  wire logic [LANE_COUNT-1:0] lane_polarity_invert_mask_i,
	output lane_bus_t      logical_lanes_o
);

	// select field of a logical lane, three bits per lane across both bytes
	function automatic logic [SEL_W-1:0] lane_select(input crossbar_t map, input int idx);
		lane_select = map[idx*SEL_W +: SEL_W];
	endfunction : lane_select

	wire lane_bus_t next_lanes;

	genvar g;
	generate
		for (g = 0; g < LANE_COUNT; g++) begin : g_lane
			logic [LANE_W-1:0] picked;
			always_comb begin
				picked = '0;
				if (lane_select(lane_crossbar_map_i, g) < SEL_W'(LANE_COUNT)) begin
					picked = phys_lanes_i[lane_select(lane_crossbar_map_i, g)];
				end
			end
			assign next_lanes[g] = lane_polarity_invert_mask_i[g] ? ~picked : picked;

			route_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
				!lane_polarity_invert_mask_i[g] && lane_select(lane_crossbar_map_i, g) == 0
				|=> logical_lanes_o[g] == $past(phys_lanes_i[0]))
				else $error("logical lane not taken from selected physical lane");
			invert_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
				lane_polarity_invert_mask_i[g] && lane_select(lane_crossbar_map_i, g) == 1
				|=> logical_lanes_o[g] == ~$past(phys_lanes_i[1]))
				else $error("logical lane polarity not inverted");
		end
	endgenerate

	// one register process for all lanes, so the output has a single driver
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			logical_lanes_o <= '0;
		end else begin
			logical_lanes_o <= next_lanes;
		end
	end

endmodule : lane_router

// ==== verilog/serdes_link_bringup_sequencer.sv ====
/*
 * Register file, PLL and clock recovery gating, frame clock sync machine and link
 * enable for the receive side of a serial converter link.
 * Assumes a byte-wide register port decoded from the serial port, and lane symbols,
 * reference edge and PLL lock all synchronous to clk_sys_i.
 */
`timescale 1ns/1ns
module serdes_link_bringup_sequencer
	import link_bringup_pkg::*;
(
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire reg_req_s     reg_req_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	output logic              reg_rvalid_o,
	input  wire logic         serdes_pll_lock_i,
	input  wire logic         sysref_i,
	input  wire lane_bus_t    phys_lanes_i,
	output phy_cfg_s          phy_cfg_o,
	output latency_cfg_s      latency_cfg_o,
	output logic              serdes_pll_enable_o,
	output logic              cdr_enable_o,
	output logic              frame_clock_aligned_o,
	output logic              link_active_o,
	output logic              checksum_mode_select_o,
	output logic              sync_request_output_n_o,
	output lane_bus_t         logical_lanes_o
);

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] lmfc_sync_control;
	logic [DATA_W-1:0] cdr_reset_control;
	logic [DATA_W-1:0] phy_clocking_setup;
	logic [DATA_W-1:0] equalizer_setup;
	logic [DATA_W-1:0] serdes_pll_enable;
	logic [DATA_W-1:0] serdes_pll_divider;
	logic [DATA_W-1:0] phy_autotune;
	logic [DATA_W-1:0] link_control;
	logic [DATA_W-1:0] link_subclass;
	logic [DATA_W-1:0] frame_clock_delay;
	logic [DATA_W-1:0] frame_clock_variability;
	logic [DATA_W-1:0] lane_crossbar_low;
	logic [DATA_W-1:0] lane_crossbar_high;
	logic [DATA_W-1:0] serdes_port_config;
	logic [DATA_W-1:0] lane_polarity_invert;

	logic              pll_locked;
	logic              sysref_prev;
	sync_state_e       sync_state;
	sync_state_e       next_sync_state;

	function automatic logic wr_hit(input reg_req_s req, input logic [ADDR_W-1:0] addr);
		wr_hit = req.wr && (req.addr == addr);
	endfunction : wr_hit

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			lmfc_sync_control       <= ZERO_BYTE;
			cdr_reset_control       <= ZERO_BYTE;
			phy_clocking_setup      <= PHY_CLOCKING_RESET;
			equalizer_setup         <= EQUALIZER_RESET;
			serdes_pll_enable       <= ZERO_BYTE;
			serdes_pll_divider      <= ZERO_BYTE;
			phy_autotune            <= ZERO_BYTE;
			link_control            <= ZERO_BYTE;
			link_subclass           <= ZERO_BYTE;
			frame_clock_delay       <= ZERO_BYTE;
			frame_clock_variability <= ZERO_BYTE;
			lane_crossbar_low       <= ZERO_BYTE;
			lane_crossbar_high      <= ZERO_BYTE;
			serdes_port_config      <= ZERO_BYTE;
			lane_polarity_invert    <= ZERO_BYTE;
		end else begin
			if (wr_hit(reg_req_i, LMFC_SYNC_CONTROL_ADDR))   lmfc_sync_control <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, CDR_RESET_CONTROL_ADDR))   cdr_reset_control <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, PHY_CLOCKING_SETUP_ADDR))  phy_clocking_setup <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, EQUALIZER_SETUP_ADDR))     equalizer_setup <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, SERDES_PLL_ENABLE_ADDR))   serdes_pll_enable <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, SERDES_PLL_DIVIDER_ADDR))  serdes_pll_divider <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, PHY_AUTOTUNE_ADDR))        phy_autotune <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, LINK_CONTROL_ADDR))        link_control <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, LINK_SUBCLASS_ADDR))       link_subclass <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, FRAME_CLOCK_DELAY_ADDR))   frame_clock_delay <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, FRAME_CLOCK_VAR_ADDR))     frame_clock_variability <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, LANE_CROSSBAR_LOW_ADDR))   lane_crossbar_low <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, LANE_CROSSBAR_HIGH_ADDR))  lane_crossbar_high <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, SERDES_PORT_CONFIG_ADDR))  serdes_port_config <= reg_req_i.wdata;
			if (wr_hit(reg_req_i, LANE_POLARITY_INV_ADDR))   lane_polarity_invert <= reg_req_i.wdata;
		end
	end

	// ------------------------------------------------------------------
	// read port, one cycle after the strobe, unmapped reads give zero
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] sync_status;
	logic [DATA_W-1:0] pll_status;
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		sync_status = ZERO_BYTE;
		sync_status[SYNC_LOCKED_BIT] = (sync_state == SYNC_LOCKED);
		sync_status[1:0] = sync_state;
		pll_status = ZERO_BYTE;
		pll_status[PLL_LOCK_BIT] = pll_locked;
	end

	always_comb begin
		case (reg_req_i.addr)
			LMFC_SYNC_CONTROL_ADDR:  next_rdata = lmfc_sync_control;
			LMFC_SYNC_STATUS_ADDR:   next_rdata = sync_status;
			CDR_RESET_CONTROL_ADDR:  next_rdata = cdr_reset_control;
			PHY_CLOCKING_SETUP_ADDR: next_rdata = phy_clocking_setup;
			EQUALIZER_SETUP_ADDR:    next_rdata = equalizer_setup;
			SERDES_PLL_ENABLE_ADDR:  next_rdata = serdes_pll_enable;
			SERDES_PLL_STATUS_ADDR:  next_rdata = pll_status;
			SERDES_PLL_DIVIDER_ADDR: next_rdata = serdes_pll_divider;
			PHY_AUTOTUNE_ADDR:       next_rdata = phy_autotune;
			LINK_CONTROL_ADDR:       next_rdata = link_control;
			LINK_SUBCLASS_ADDR:      next_rdata = link_subclass;
			FRAME_CLOCK_DELAY_ADDR:  next_rdata = frame_clock_delay;
			FRAME_CLOCK_VAR_ADDR:    next_rdata = frame_clock_variability;
			LANE_CROSSBAR_LOW_ADDR:  next_rdata = lane_crossbar_low;
			LANE_CROSSBAR_HIGH_ADDR: next_rdata = lane_crossbar_high;
			SERDES_PORT_CONFIG_ADDR: next_rdata = serdes_port_config;
			LANE_POLARITY_INV_ADDR:  next_rdata = lane_polarity_invert;
			default:                 next_rdata = ZERO_BYTE;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o  <= ZERO_BYTE;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_req_i.rd;
			if (reg_req_i.rd) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// serdes PLL and clock recovery
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			serdes_pll_enable_o <= 1'b0;
			pll_locked          <= 1'b0;
			cdr_enable_o        <= 1'b0;
		end else begin
			serdes_pll_enable_o <= serdes_pll_enable[PLL_ENABLE_BIT];
			pll_locked          <= serdes_pll_enable_o && serdes_pll_lock_i;
			cdr_enable_o        <= cdr_reset_control[CDR_RELEASE_BIT] && pll_locked;
		end
	end

	// ------------------------------------------------------------------
	// frame clock sync machine
	// ------------------------------------------------------------------
	logic sync_wr;
	logic sysref_edge;
	logic subclass_one;
	logic capture_now;

	assign sync_wr      = wr_hit(reg_req_i, LMFC_SYNC_CONTROL_ADDR);
	assign sysref_edge  = sysref_i && !sysref_prev;
	assign subclass_one = (link_subclass == SUBCLASS_ONE);
	// subclass 0 needs no reference edge, so an armed machine locks at once
	assign capture_now  = (sync_state == SYNC_ARMED) && (sysref_edge || !subclass_one);

	always_comb begin
		next_sync_state = sync_state;
		if (sync_wr) begin
			if (!reg_req_i.wdata[SYNC_ENABLE_BIT]) begin
				next_sync_state = SYNC_IDLE;
			end else if (reg_req_i.wdata[SYNC_ARM_BIT]
				&& reg_req_i.wdata[SYNC_MODE_LSB +: 2] == SYNC_MODE_ONE_SHOT) begin
				next_sync_state = capture_now ? SYNC_LOCKED : SYNC_ARMED;
			end else begin
				next_sync_state = SYNC_ENABLED;
			end
		end else begin
			case (sync_state)
				SYNC_IDLE:    next_sync_state = SYNC_IDLE;
				SYNC_ENABLED: next_sync_state = SYNC_ENABLED;
				SYNC_ARMED:   next_sync_state = capture_now ? SYNC_LOCKED : SYNC_ARMED;
				SYNC_LOCKED:  next_sync_state = SYNC_LOCKED;
				default:      next_sync_state = SYNC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sync_state            <= SYNC_IDLE;
			sysref_prev           <= 1'b0;
			frame_clock_aligned_o <= 1'b0;
		end else begin
			sync_state            <= next_sync_state;
			sysref_prev           <= sysref_i;
			frame_clock_aligned_o <= (next_sync_state == SYNC_LOCKED);
		end
	end

	// ------------------------------------------------------------------
	// link enable and configuration outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			link_active_o           <= 1'b0;
			checksum_mode_select_o  <= 1'b0;
			sync_request_output_n_o <= 1'b0;
			phy_cfg_o               <= '0;
			latency_cfg_o           <= '0;
		end else begin
			link_active_o <= link_control[LINK_ENABLE_BIT] && cdr_enable_o
				&& (sync_state == SYNC_LOCKED || !subclass_one);
			checksum_mode_select_o  <= link_control[CHECKSUM_MODE_BIT];
			// sync request held low until the link is running
			sync_request_output_n_o <= link_active_o;
			phy_cfg_o.halfrate                 <= phy_clocking_setup[HALFRATE_BIT];
			phy_cfg_o.pll_cfg                  <= phy_clocking_setup[PLL_CFG_LSB +: 3];
			phy_cfg_o.cdr_oversample_select    <= phy_clocking_setup[OVERSAMPLE_BIT];
			phy_cfg_o.sync_swing               <= phy_clocking_setup[SWING_BIT];
			phy_cfg_o.serdes_pll_divider_value <= serdes_pll_divider[1:0];
			phy_cfg_o.divider_cfg              <= serdes_pll_divider[DIV_CFG_BIT];
			phy_cfg_o.equalizer_mode_select    <= equalizer_setup[EQ_MODE_LSB +: 2];
			phy_cfg_o.equalizer_trim           <= equalizer_setup[5:0];
			latency_cfg_o.frame_clock_delay_value       <= frame_clock_delay;
			latency_cfg_o.frame_clock_variability_value <= frame_clock_variability;
		end
	end

	lane_router u_lane_router (
		.clk_sys_i                   (clk_sys_i),
		.rst_i                       (rst_i),
		.phys_lanes_i                (phys_lanes_i),
		.lane_crossbar_map_i         ({lane_crossbar_high, lane_crossbar_low}),
		.lane_polarity_invert_mask_i (lane_polarity_invert[LANE_COUNT-1:0]),
		.logical_lanes_o             (logical_lanes_o)
	);

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	cdr_idle_a: assert property (!cdr_reset_control[CDR_RELEASE_BIT] |=> !cdr_enable_o)
		else $error("clock recovery running while held in reset");
	pll_enable_a: assert property (
		wr_hit(reg_req_i, SERDES_PLL_ENABLE_ADDR) && reg_req_i.wdata == PLL_ENABLE_CMD
		|=> ##1 serdes_pll_enable_o)
		else $error("serdes PLL not enabled after enable write");
	pll_status_a: assert property (
		reg_req_i.rd && reg_req_i.addr == SERDES_PLL_STATUS_ADDR
		|=> reg_rvalid_o && reg_rdata_o[PLL_LOCK_BIT] == $past(pll_locked))
		else $error("PLL status bit does not show lock");
	one_shot_a: assert property (
		sync_wr && reg_req_i.wdata == SYNC_CMD_ONE_SHOT
		|=> sync_state == SYNC_IDLE && lmfc_sync_control == SYNC_CMD_ONE_SHOT)
		else $error("one-shot mode write not taken");
	sync_enable_a: assert property (sync_wr && reg_req_i.wdata == SYNC_CMD_ENABLE
		|=> sync_state == SYNC_ENABLED)
		else $error("sync machine not enabled");
	sync_arm_a: assert property (sync_wr && reg_req_i.wdata == SYNC_CMD_ARM && !capture_now
		|=> sync_state == SYNC_ARMED)
		else $error("sync machine not armed");
	lock_status_a: assert property (
		sync_state == SYNC_ARMED && subclass_one && sysref_edge && !sync_wr
		|=> sync_state == SYNC_LOCKED && sync_status[SYNC_LOCKED_BIT]
		&& frame_clock_aligned_o)
		else $error("sync lock not reported after reference edge");
	link_start_a: assert property ($rose(link_active_o)
		|-> $past(link_control[LINK_ENABLE_BIT]) && $past(cdr_enable_o))
		else $error("link started without enable or recovered clock");
	cdr_run_a: assert property (
		cdr_reset_control[CDR_RELEASE_BIT] && pll_locked |=> cdr_enable_o)
		else $error("clock recovery not released after reset write");
	pll_lock_a: assert property (
		serdes_pll_enable_o && serdes_pll_lock_i |=> pll_locked)
		else $error("PLL lock not captured");
	read_answer_a: assert property (reg_req_i.rd |=> reg_rvalid_o)
		else $error("read strobe not answered");
	link_wait_a: assert property (
		subclass_one && sync_state != SYNC_LOCKED |=> !link_active_o)
		else $error("link started before frame clock lock");
	link_enable_a: assert property (
		link_control[LINK_ENABLE_BIT] && cdr_enable_o && sync_state == SYNC_LOCKED
		|=> link_active_o)
		else $error("link not started after enable");
	sync_hold_a: assert property (
		!link_active_o |=> !sync_request_output_n_o)
		else $error("sync request released while link idle");

	// ------------------------------------------------------------------
	// cover points
	// ------------------------------------------------------------------
	pll_lock_c: cover property ($rose(pll_locked));
	armed_lock_c: cover property (!subclass_one && sync_state == SYNC_ARMED
		##1 sync_state == SYNC_LOCKED);
	sync_lock_c: cover property (sync_state == SYNC_ARMED ##1 sync_state == SYNC_LOCKED);
	link_up_c: cover property ($rose(link_active_o) ##1 sync_request_output_n_o);

endmodule : serdes_link_bringup_sequencer

// ==== dv/link_tx_model.sv ====
/*
 * Behavioural model of the far-side link transmitter: lane symbols and reference edges.
 * Assumes the bench pulses send_sysref_i for one cycle to request a reference edge.
 */
`timescale 1ns/1ns
module link_tx_model
	import link_bringup_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic send_sysref_i,
	output logic      sysref_o,
	output lane_bus_t lanes_o
);
	logic [2:0] pulse_cnt;
	logic [9:0] sym;

	// ----------------------------------------
	// lane symbols change every cycle
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sym     <= 10'h155;
			lanes_o <= '0;
		end else begin
			sym <= {sym[8:0], sym[9] ^ sym[6]};
			for (int i = 0; i < LANE_COUNT; i++) begin
				lanes_o[i] <= sym ^ (10'h0c7 * i[9:0]);
			end
		end
	end

	// ----------------------------------------
	// reference edge: a four-cycle high pulse
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pulse_cnt <= 3'h0;
			sysref_o  <= 1'b0;
		end else begin
			if (send_sysref_i && pulse_cnt == 3'h0) begin
				pulse_cnt <= 3'h4;
			end else if (pulse_cnt != 3'h0) begin
				pulse_cnt <= pulse_cnt - 3'h1;
			end
			sysref_o <= (pulse_cnt != 3'h0);
		end
	end
endmodule : link_tx_model

// ==== dv/tb.sv ====
/*
 * Self-checking bench for the link bring-up sequencer: registers, PLL, sync, lanes, link.
 * Assumes the transmitter model on the lane side; the bench plays host and PLL lock.
 */
`timescale 1ns/1ns
module tb
	import link_bringup_pkg::*;
;
	logic clk_sys_i, rst_i, lock, send, sysref, rvalid, pll_en, cdr_en, aligned, active, cks, sync_n;
	reg_req_s     req;
	logic [7:0]   rdata, exp_q[$], d230, d289, d268;
	lane_bus_t    phys, logical, p;
	phy_cfg_s     phy_cfg;
	latency_cfg_s lat;
	int           n_fail, comparisons;
	integer       seed = 32'h9e75;
	logic [31:0]  r;
	logic [3:0]   inv;

	serdes_link_bringup_sequencer u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .serdes_pll_lock_i(lock), .sysref_i(sysref),
		.phys_lanes_i(phys), .phy_cfg_o(phy_cfg), .latency_cfg_o(lat), .serdes_pll_enable_o(pll_en),
		.cdr_enable_o(cdr_en), .frame_clock_aligned_o(aligned), .link_active_o(active),
		.checksum_mode_select_o(cks), .sync_request_output_n_o(sync_n), .logical_lanes_o(logical));
	link_tx_model u_tx (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .send_sysref_i(send),
		.sysref_o(sysref), .lanes_o(phys));

	// ----------------------------------------
	// clock, shared tasks
	// ----------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		req <= '0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		exp_q.push_back(e);
		@(posedge clk_sys_i);
		req <= '0;
	endtask : rd
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask : wait_n
	task automatic note(input string s);
		$display("test %s done", s);
	endtask : note
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	function automatic lane_bus_t route(lane_bus_t ph, crossbar_t m, logic [3:0] iv);
		lane_bus_t o;
		for (int i = 0; i < LANE_COUNT; i++) begin
			o[i] = (m[3*i+:3] < 3'h4) ? ph[m[3*i+:2]] : '0;
			if (iv[i]) o[i] = ~o[i];
		end
		return o;
	endfunction : route

	// ----------------------------------------
	// read monitor and watchdog
	// ----------------------------------------
	always @(negedge clk_sys_i) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) chk(rdata, 'x, "unexpected read");
			else chk(rdata, exp_q.pop_front(), "read data");
		end
	end
	initial begin
		#100000;
		n_fail++;
		complete_run();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_i = 1'b1; req = '0; lock = 1'b0; send = 1'b0;
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(PHY_CLOCKING_SETUP_ADDR, 8'h09); rd(EQUALIZER_SETUP_ADDR, 8'h22); rd(12'h123, 8'h00);
		wr(SERDES_PLL_STATUS_ADDR, 8'hff); rd(SERDES_PLL_STATUS_ADDR, 8'h00);
		wr(LMFC_SYNC_STATUS_ADDR, 8'hff); rd(LMFC_SYNC_STATUS_ADDR, 8'h00);
		note("reset");
		r = $random(seed);
		d230 = {r[7:6], r[5], 3'h2, r[1:0]}; d289 = {r[15:11], 1'b1, r[9:8]}; d268 = {r[23:22], 6'h22};
		wr(PHY_CLOCKING_SETUP_ADDR, d230); wr(SERDES_PLL_DIVIDER_ADDR, d289);
		wr(EQUALIZER_SETUP_ADDR, d268); wr(FRAME_CLOCK_DELAY_ADDR, r[31:24]);
		wr(FRAME_CLOCK_VAR_ADDR, r[15:8]); wr(LINK_SUBCLASS_ADDR, SUBCLASS_ONE);
		wait_n(2);
		chk(phy_cfg, {d230[5:0], d289[1:0], d289[2], d268}, "phy config");
		chk(lat, {r[31:24], r[15:8]}, "latency config");
		rd(PHY_CLOCKING_SETUP_ADDR, d230); rd(LINK_SUBCLASS_ADDR, SUBCLASS_ONE);
		note("config");
		wr(CDR_RESET_CONTROL_ADDR, 8'h00); lock <= 1'b1; wr(SERDES_PLL_ENABLE_ADDR, 8'h01);
		wait_n(4);
		chk(pll_en, 1'b1, "pll enable");
		chk(cdr_en, 1'b0, "recovery held");
		rd(SERDES_PLL_STATUS_ADDR, 8'h01);
		wr(CDR_RESET_CONTROL_ADDR, 8'h01);
		wait_n(2);
		chk(cdr_en, 1'b1, "recovery running");
		note("pll");
		wr(LMFC_SYNC_CONTROL_ADDR, 8'h01); rd(LMFC_SYNC_STATUS_ADDR, 8'h00);
		wr(LMFC_SYNC_CONTROL_ADDR, 8'h81); rd(LMFC_SYNC_STATUS_ADDR, 8'h01);
		wr(LMFC_SYNC_CONTROL_ADDR, 8'hc1); rd(LMFC_SYNC_STATUS_ADDR, 8'h02);
		wr(LINK_CONTROL_ADDR, 8'h41);
		wait_n(3);
		chk(aligned, 1'b0, "aligned before edge");
		chk(active, 1'b0, "link waits for sync");
		@(posedge clk_sys_i); send <= 1'b1;
		@(posedge clk_sys_i); send <= 1'b0;
		wait_n(8);
		chk(aligned, 1'b1, "aligned");
		rd(LMFC_SYNC_STATUS_ADDR, 8'h0b);
		wait_n(3);
		chk({active, cks, sync_n}, 3'b111, "link running");
		note("sync and link");
		wr(LINK_SUBCLASS_ADDR, 8'h00); wr(LMFC_SYNC_CONTROL_ADDR, 8'h81);
		rd(LMFC_SYNC_STATUS_ADDR, 8'h01);
		wr(LMFC_SYNC_CONTROL_ADDR, 8'hc1); rd(LMFC_SYNC_STATUS_ADDR, 8'h0b);
		wait_n(2);
		chk({aligned, active}, 2'b11, "subclass 0 lock");
		note("subclass 0");
		// first pass: every lane on physical lane 1, all inverted
		for (int k = 0; k < 9; k++) begin
			r = (k == 0) ? 32'h000f_0249 : $random(seed);
			inv = r[19:16];
			for (int i = 0; i < LANE_COUNT; i++) if (r[3*i+2]) inv[i] = 1'b0;
			wr(LANE_CROSSBAR_LOW_ADDR, r[7:0]); wr(LANE_CROSSBAR_HIGH_ADDR, r[15:8]);
			wr(LANE_POLARITY_INV_ADDR, {4'h0, inv});
			wait_n(1);
			p = phys;
			@(negedge clk_sys_i);
			chk(logical, route(p, r[15:0], inv), "lanes");
		end
		note("lanes");
		wait_n(3);
		chk(exp_q.size(), 0, "reads answered");
		complete_run();
	end
endmodule : tb
